//--- pcb_defines.svh
// Constants of the program counter break unit: offsets, fields, codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PCB_DEFINES_SVH
`define PCB_DEFINES_SVH

`define PCB_ADDR_W          24
`define PCB_REG_AW          8
`define PCB_OFF_BRK_ADDR_A  8'h00
`define PCB_OFF_BRK_ADDR_B  8'h04
`define PCB_OFF_CTL_A       8'h08
`define PCB_OFF_CTL_B       8'h0C
`define PCB_OFF_IRQ_STAT    8'h10
`define PCB_OFF_IRQ_MASK    8'h14

`define PCB_CTL_FLAG_BIT    7
`define PCB_CTL_MSTR_BIT    6
`define PCB_CTL_MASK_HI     5
`define PCB_CTL_MASK_LO     3
`define PCB_CTL_CYC_HI      2
`define PCB_CTL_CYC_LO      1
`define PCB_CTL_RST         6'h00

`define PCB_MASK_CODE5_BITS 5'h08
`define PCB_MASK_CODE6_BITS 5'h0C
`define PCB_MASK_CODE7_BITS 5'h10

`define PCB_IRQ_BIT_A       0
`define PCB_IRQ_BIT_B       1
`define PCB_RESP_OKAY       2'h0
`define PCB_RESP_SLVERR     2'h2

`endif

//--- pcb_pkg.sv
// Types shared by the program counter break unit.
// Assumes pcb_defines.svh is on the include path.
`include "pcb_defines.svh"

package pcb_pkg;

    typedef enum logic [1:0]
    {
        PCB_CYC_FETCH = 2'b00,
        PCB_CYC_READ  = 2'b01,
        PCB_CYC_WRITE = 2'b10,
        PCB_CYC_DATA  = 2'b11
    } pcb_cycle_type;

    typedef enum logic [1:0]
    {
        PCB_WR_COLLECT = 2'b00,
        PCB_WR_RESP    = 2'b01
    } pcb_wr_state_type;

endpackage : pcb_pkg

//--- pcb_channel.sv
// One break channel: address comparator, qualifiers and match flag.
// Assumes bus cycle inputs are synchronous to ref_clk, one cycle each.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defines.svh"

module pcb_channel
    import pcb_pkg::*;
#(
    parameter int ADDR_W = `PCB_ADDR_W
)
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [ADDR_W-1:0] brk_addr,
    input  wire logic [2:0]        mask_code,
    input  wire logic              master_any,
    input  wire logic [1:0]        cycle_sel,
    input  wire logic              bus_valid,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic              bus_fetch,
    input  wire logic              bus_read,
    input  wire logic              bus_write,
    input  wire logic              bus_xfer,
    input  wire logic              flag_clr,
    output logic                   match_flag,
    output logic                   hit
);

    logic              flag_r;
    logic              flag_nxt;
    logic [4:0]        ign_bits;
    logic [ADDR_W-1:0] cmp_mask;
    logic              cyc_ok;
    logic              mstr_ok;

    // ****************************************************************
    // Comparator
    // ****************************************************************
    always_comb
    begin
        case (mask_code)
            3'h5:    ign_bits = `PCB_MASK_CODE5_BITS;
            3'h6:    ign_bits = `PCB_MASK_CODE6_BITS;
            3'h7:    ign_bits = `PCB_MASK_CODE7_BITS;
            default: ign_bits = {2'b00, mask_code};
        endcase
        cmp_mask = {ADDR_W{1'b1}} << ign_bits;
        case (pcb_cycle_type'(cycle_sel))
            PCB_CYC_FETCH: cyc_ok = bus_fetch;
            PCB_CYC_READ:  cyc_ok = bus_read;
            PCB_CYC_WRITE: cyc_ok = bus_write;
            default:       cyc_ok = bus_read | bus_write;
        endcase
        mstr_ok = ~bus_xfer | master_any;
        hit = bus_valid & cyc_ok & mstr_ok
            & (((bus_addr ^ brk_addr) & cmp_mask) == '0);
        // A match in the cycle of a clear wins over the clear.
        flag_nxt = hit | (flag_r & ~flag_clr);
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            flag_r <= 1'b0;
        else
            flag_r <= flag_nxt;
    end

    assign match_flag = flag_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_hit_sets_flag;
        @(posedge ref_clk) disable iff (sys_rst)
        hit |=> match_flag;
    endproperty
    a_hit_sets_flag: assert property (p_hit_sets_flag)
        else $error("Match did not set the flag.");

    property p_flag_holds;
        @(posedge ref_clk) disable iff (sys_rst)
        match_flag && !flag_clr |=> match_flag;
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("Flag dropped without a clear.");

    property p_cpu_only;
        @(posedge ref_clk) disable iff (sys_rst)
        bus_xfer && !master_any |-> !hit;
    endproperty
    a_cpu_only: assert property (p_cpu_only)
        else $error("Transfer cycle matched in CPU-only mode.");

    property p_mask16;
        @(posedge ref_clk) disable iff (sys_rst)
        bus_valid && bus_read && !bus_xfer && mask_code == 3'h7
            && cycle_sel == 2'b01
            && bus_addr[ADDR_W-1:16] == brk_addr[ADDR_W-1:16]
        |-> hit ##1 match_flag;
    endproperty
    a_mask16: assert property (p_mask16)
        else $error("Masked compare of 16 low bits missed.");

    property p_fetch_only;
        @(posedge ref_clk) disable iff (sys_rst)
        hit && cycle_sel == 2'b00 |-> bus_fetch;
    endproperty
    a_fetch_only: assert property (p_fetch_only)
        else $error("Fetch break matched a non-fetch cycle.");

endmodule : pcb_channel
`default_nettype wire

//--- pcb_top.sv
// Program counter break unit: two break channels behind AXI4-Lite.
// Assumes the observed bus cycle signals come from logic on ref_clk.
//
// What this block does
// - A channel A break condition match sets match flag bit 7.
// - Flag clears only by writing 0 after reading 1; writing 1 ignored.
// - Bit 6 at 0 qualifies CPU cycles; at 1 CPU or transfer cycles.
// - Mask codes 0-4 ignore 0-4 low bits; 5,6,7 ignore 8,12,16.
// - Cycle code: 00 fetch, 01 read, 10 write, 11 read or write.
// - Channel B has its own break address, compared the same way.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defines.svh"

module pcb_top
    import pcb_pkg::*;
#(
    parameter int ADDR_W = `PCB_ADDR_W
)
(
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    input  wire logic [31:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [31:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              bus_valid,
    input  wire logic [ADDR_W-1:0] bus_addr,
    input  wire logic              bus_fetch,
    input  wire logic              bus_read,
    input  wire logic              bus_write,
    input  wire logic              bus_xfer,
    output logic                   brk_irq
);

    pcb_wr_state_type  wst_r, wst_nxt;
    logic              aw_held_r, aw_held_nxt;
    logic              w_held_r, w_held_nxt;
    logic [7:0]        waddr_r, waddr_nxt;
    logic [31:0]       wdata_r, wdata_nxt;
    logic [3:0]        wstrb_r, wstrb_nxt;
    logic [1:0]        bresp_r, bresp_nxt;
    logic              rvalid_r, rvalid_nxt;
    logic [31:0]       rdata_r, rdata_nxt;
    logic [1:0]        rresp_r, rresp_nxt;
    logic [ADDR_W-1:0] addr_a_r, addr_a_nxt;
    logic [ADDR_W-1:0] addr_b_r, addr_b_nxt;
    logic [5:0]        ctl_a_r, ctl_a_nxt;
    logic [5:0]        ctl_b_r, ctl_b_nxt;
    logic              arm_a_r, arm_a_nxt;
    logic              arm_b_r, arm_b_nxt;
    logic [1:0]        stat_r, stat_nxt;
    logic [1:0]        mask_r, mask_nxt;
    logic              flag_a, flag_b, hit_a, hit_b;
    logic              clr_a, clr_b;
    logic              do_wr;
    logic [31:0]       wmerge;
    logic [31:0]       rmux;
    logic              rok;
    logic [1:0]        evt;

    // ****************************************************************
    // Break channels
    // ****************************************************************
    pcb_channel #(.ADDR_W(ADDR_W)) u_chan_a
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .brk_addr   (addr_a_r),
        .mask_code  (ctl_a_r[`PCB_CTL_MASK_HI-1:`PCB_CTL_MASK_LO-1]),
        .master_any (ctl_a_r[`PCB_CTL_MSTR_BIT-1]),
        .cycle_sel  (ctl_a_r[`PCB_CTL_CYC_HI-1:`PCB_CTL_CYC_LO-1]),
        .bus_valid  (bus_valid),
        .bus_addr   (bus_addr),
        .bus_fetch  (bus_fetch),
        .bus_read   (bus_read),
        .bus_write  (bus_write),
        .bus_xfer   (bus_xfer),
        .flag_clr   (clr_a),
        .match_flag (flag_a),
        .hit        (hit_a)
    );

    // Channel B is a full copy so that its compare is independent.
    pcb_channel #(.ADDR_W(ADDR_W)) u_chan_b
    (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .brk_addr   (addr_b_r),
        .mask_code  (ctl_b_r[`PCB_CTL_MASK_HI-1:`PCB_CTL_MASK_LO-1]),
        .master_any (ctl_b_r[`PCB_CTL_MSTR_BIT-1]),
        .cycle_sel  (ctl_b_r[`PCB_CTL_CYC_HI-1:`PCB_CTL_CYC_LO-1]),
        .bus_valid  (bus_valid),
        .bus_addr   (bus_addr),
        .bus_fetch  (bus_fetch),
        .bus_read   (bus_read),
        .bus_write  (bus_write),
        .bus_xfer   (bus_xfer),
        .flag_clr   (clr_b),
        .match_flag (flag_b),
        .hit        (hit_b)
    );

    // ****************************************************************
    // Register bus and interrupt next state
    // ****************************************************************
    assign s_axi_awready = (wst_r == PCB_WR_COLLECT) & ~aw_held_r;
    assign s_axi_wready  = (wst_r == PCB_WR_COLLECT) & ~w_held_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid  = (wst_r == PCB_WR_RESP);
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign brk_irq       = |(stat_r & mask_r);

    always_comb
    begin
        wst_nxt     = wst_r;
        aw_held_nxt = aw_held_r;
        w_held_nxt  = w_held_r;
        waddr_nxt   = waddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        addr_a_nxt  = addr_a_r;
        addr_b_nxt  = addr_b_r;
        ctl_a_nxt   = ctl_a_r;
        ctl_b_nxt   = ctl_b_r;
        arm_a_nxt   = arm_a_r;
        arm_b_nxt   = arm_b_r;
        mask_nxt    = mask_r;
        clr_a       = 1'b0;
        clr_b       = 1'b0;
        rmux        = 32'h0000_0000;
        rok         = 1'b1;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_nxt = 1'b1;
            waddr_nxt   = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_nxt = 1'b1;
            wdata_nxt  = s_axi_wdata;
            wstrb_nxt  = s_axi_wstrb;
        end
        for (int i = 0; i < 4; i++)
            wmerge[i*8 +: 8] = wstrb_r[i] ? wdata_r[i*8 +: 8] : 8'h00;
        do_wr = (wst_r == PCB_WR_COLLECT) & aw_held_r & w_held_r;
        // Interrupt status: a new flag set beats a same-cycle clear.
        evt      = {hit_b & ~flag_b, hit_a & ~flag_a};
        stat_nxt = stat_r;
        if (do_wr)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt  = 1'b0;
            wst_nxt     = PCB_WR_RESP;
            bresp_nxt   = `PCB_RESP_OKAY;
            case (waddr_r)
                `PCB_OFF_BRK_ADDR_A:
                    for (int i = 0; i < 3; i++)
                        if (wstrb_r[i])
                            addr_a_nxt[i*8 +: 8] = wdata_r[i*8 +: 8];
                `PCB_OFF_BRK_ADDR_B:
                    for (int i = 0; i < 3; i++)
                        if (wstrb_r[i])
                            addr_b_nxt[i*8 +: 8] = wdata_r[i*8 +: 8];
                `PCB_OFF_CTL_A:
                    if (wstrb_r[0])
                    begin
                        ctl_a_nxt = wdata_r[`PCB_CTL_MSTR_BIT:1];
                        // Only a zero after a read of one clears.
                        clr_a = arm_a_r
                            & ~wdata_r[`PCB_CTL_FLAG_BIT];
                        arm_a_nxt = 1'b0;
                    end
                `PCB_OFF_CTL_B:
                    if (wstrb_r[0])
                    begin
                        ctl_b_nxt = wdata_r[`PCB_CTL_MSTR_BIT:1];
                        clr_b = arm_b_r & ~wdata_r[`PCB_CTL_FLAG_BIT];
                        arm_b_nxt = 1'b0;
                    end
                `PCB_OFF_IRQ_STAT:
                    stat_nxt = stat_r & ~wmerge[1:0];
                `PCB_OFF_IRQ_MASK:
                    mask_nxt = wmerge[1:0];
                default:
                    bresp_nxt = `PCB_RESP_SLVERR;
            endcase
        end
        else if (wst_r == PCB_WR_RESP && s_axi_bready)
            wst_nxt = PCB_WR_COLLECT;
        stat_nxt = stat_nxt | evt;
        case (s_axi_araddr[7:0])
            `PCB_OFF_BRK_ADDR_A: rmux[ADDR_W-1:0] = addr_a_r;
            `PCB_OFF_BRK_ADDR_B: rmux[ADDR_W-1:0] = addr_b_r;
            `PCB_OFF_CTL_A:      rmux[7:0] = {flag_a, ctl_a_r, 1'b0};
            `PCB_OFF_CTL_B:      rmux[7:0] = {flag_b, ctl_b_r, 1'b0};
            `PCB_OFF_IRQ_STAT:   rmux[1:0] = stat_r;
            `PCB_OFF_IRQ_MASK:   rmux[1:0] = mask_r;
            default:             rok = 1'b0;
        endcase
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rdata_nxt  = rmux;
            rresp_nxt  = rok ? `PCB_RESP_OKAY : `PCB_RESP_SLVERR;
            if (s_axi_araddr[7:0] == `PCB_OFF_CTL_A && flag_a)
                arm_a_nxt = 1'b1;
            if (s_axi_araddr[7:0] == `PCB_OFF_CTL_B && flag_b)
                arm_b_nxt = 1'b1;
        end
        else if (rvalid_r && s_axi_rready)
            rvalid_nxt = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wst_r     <= PCB_WR_COLLECT;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            waddr_r   <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bresp_r   <= `PCB_RESP_OKAY;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `PCB_RESP_OKAY;
            addr_a_r  <= '0;
            addr_b_r  <= '0;
            ctl_a_r   <= `PCB_CTL_RST;
            ctl_b_r   <= `PCB_CTL_RST;
            arm_a_r   <= 1'b0;
            arm_b_r   <= 1'b0;
            stat_r    <= 2'h0;
            mask_r    <= 2'h0;
        end
        else
        begin
            wst_r     <= wst_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r  <= w_held_nxt;
            waddr_r   <= waddr_nxt;
            wdata_r   <= wdata_nxt;
            wstrb_r   <= wstrb_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rdata_r   <= rdata_nxt;
            rresp_r   <= rresp_nxt;
            addr_a_r  <= addr_a_nxt;
            addr_b_r  <= addr_b_nxt;
            ctl_a_r   <= ctl_a_nxt;
            ctl_b_r   <= ctl_b_nxt;
            arm_a_r   <= arm_a_nxt;
            arm_b_r   <= arm_b_nxt;
            stat_r    <= stat_nxt;
            mask_r    <= mask_nxt;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_clear_needs_arm;
        @(posedge ref_clk) disable iff (sys_rst)
        $fell(flag_a) |-> $past(do_wr) && $past(arm_a_r)
            && !$past(wdata_r[`PCB_CTL_FLAG_BIT]);
    endproperty
    a_clear_needs_arm: assert property (p_clear_needs_arm)
        else $error("Flag A cleared without a prior read of one.");

    property p_chan_b;
        @(posedge ref_clk) disable iff (sys_rst)
        hit_b && !hit_a && !flag_a |=> flag_b && !flag_a;
    endproperty
    a_chan_b: assert property (p_chan_b)
        else $error("Channel B match not independent of channel A.");

    property p_irq;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(flag_a) && mask_r[`PCB_IRQ_BIT_A]
            && $past(mask_r[`PCB_IRQ_BIT_A])
        |-> brk_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("New flag A did not raise the interrupt.");

endmodule : pcb_top
`default_nettype wire

//--- pcb_bus_model.sv
// Behavioural model of the on-chip bus masters seen by the break unit.
// Assumes one request pulse per bus cycle, driven just after ref_clk rises.
`timescale 1ns/1ps
`default_nettype none

module pcb_bus_model
(
    input  wire logic        ref_clk,
    input  wire logic        go,
    input  wire logic [1:0]  kind,
    input  wire logic [23:0] addr,
    input  wire logic        xfer,
    output logic             bus_valid,
    output logic [23:0]      bus_addr,
    output logic             bus_fetch,
    output logic             bus_read,
    output logic             bus_write,
    output logic             bus_xfer
);
    // ************************************************************
    // Bus cycle generation
    // ************************************************************
    initial
    begin
        bus_valid = 1'h0;
        bus_addr  = 24'h0;
        bus_fetch = 1'h0;
        bus_read  = 1'h0;
        bus_write = 1'h0;
        bus_xfer  = 1'h0;
    end

    // Between cycles every line but bus_valid flips each clock, so a comparator
    // that ignores bus_valid sees the stale address again every second clock.
    always @(posedge ref_clk)
    begin
        bus_valid <= go;
        if (go)
        begin
            bus_addr  <= addr;
            bus_fetch <= (kind == 2'h0);
            bus_read  <= (kind == 2'h1);
            bus_write <= (kind == 2'h2);
            bus_xfer  <= xfer;
        end
        else
        begin
            bus_addr  <= ~bus_addr;
            bus_fetch <= ~bus_fetch;
            bus_read  <= ~bus_read;
            bus_write <= ~bus_write;
            bus_xfer  <= ~bus_xfer;
        end
    end
endmodule : pcb_bus_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench of the break unit: AXI4-Lite master and bus model.
// Assumes pcb_defines.svh on the include path and pcb_pkg compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_defines.svh"

module testbench;
    import pcb_pkg::*;
    logic              ref_clk = 1'h0;
    logic              sys_rst = 1'h1;
    logic [31:0]       s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0]       s_axi_araddr = 32'h0;
    logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic              s_axi_bready = 1'h0, s_axi_rready = 1'h0;
    logic              s_axi_arvalid = 1'h0;
    logic [3:0]        s_axi_wstrb = 4'hF;
    wire logic         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire logic         s_axi_arready, s_axi_rvalid, brk_irq;
    wire logic [1:0]   s_axi_bresp, s_axi_rresp;
    wire logic [31:0]  s_axi_rdata;
    wire logic         bus_valid, bus_fetch, bus_read, bus_write, bus_xfer;
    wire logic [23:0]  bus_addr;
    logic              go = 1'h0, xfer = 1'h0;
    logic [1:0]        kind = 2'h0;
    logic [23:0]       addr = 24'h0;
    logic [1:0]        last_resp;
    int                n_errors = 0;
    int                n_checks = 0;

    always #20 ref_clk = ~ref_clk;

    pcb_top dut (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_valid, .bus_addr,
        .bus_fetch, .bus_read, .bus_write, .bus_xfer, .brk_irq);

    pcb_bus_model model (.ref_clk, .go, .kind, .addr, .xfer, .bus_valid,
        .bus_addr, .bus_fetch, .bus_read, .bus_write, .bus_xfer);

    // ************************************************************
    // Tasks and expectations
    // ************************************************************
    task automatic stop_test();
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        @(posedge ref_clk);
        s_axi_awaddr  <= {24'h0, a};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        aw = 0;
        w = 0;
        while (!(aw && w))
        begin
            @(posedge ref_clk);
            if (!aw && s_axi_awready === 1'h1)
            begin
                aw = 1;
                s_axi_awvalid <= 1'h0;
            end
            if (!w && s_axi_wready === 1'h1)
            begin
                w = 1;
                s_axi_wvalid <= 1'h0;
            end
        end
        while (s_axi_bvalid !== 1'h1) @(posedge ref_clk);
        last_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        s_axi_araddr  <= {24'h0, a};
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do @(posedge ref_clk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        while (s_axi_rvalid !== 1'h1) @(posedge ref_clk);
        last_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        check(s_axi_rdata, exp);
    endtask : rd_chk

    task automatic bus_cycle(input logic [23:0] a, input logic [1:0] k,
                             input logic x);
        @(posedge ref_clk);
        go   <= 1'h1;
        addr <= a;
        kind <= k;
        xfer <= x;
        @(posedge ref_clk);
        go   <= 1'h0;
    endtask : bus_cycle

    function automatic logic exp_hit(input logic [23:0] brk,
        input logic [7:0] cfg, input logic [23:0] a, input logic [1:0] k,
        input logic x);
        int          n;
        logic [23:0] m;
        logic        ty;
        n = int'(cfg[5:3]);
        if (n > 4)
            n = (n - 3) * 4;
        m = 24'hFFFFFF << n;
        ty = (cfg[2:1] == 2'h3) ? (k != 2'h0) : (k == cfg[2:1]);
        return ((brk & m) == (a & m)) && ty && (!x || cfg[6]);
    endfunction : exp_hit

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        logic [23:0] brk [2];
        logic [7:0]  cfg [2];
        logic [23:0] a;
        logic [1:0]  k, m, hv;
        logic        x;
        void'($urandom(33720));
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'h0;
        // Every register starts at zero; the first unused word is refused.
        for (int o = 0; o <= 8'h18; o += 4)
        begin
            rd_chk(8'(o), 32'h0);
            check(last_resp, (o == 8'h18) ? `PCB_RESP_SLVERR
                                          : `PCB_RESP_OKAY);
        end
        wr(8'h1C, 32'h0);
        check(last_resp, `PCB_RESP_SLVERR);
        check(brk_irq, 1'h0);
        // Only strobed lanes of a break address word are written.
        s_axi_wstrb <= 4'h3;
        wr(`PCB_OFF_BRK_ADDR_B, 32'hFFFF_FFFF);
        s_axi_wstrb <= 4'hF;
        rd_chk(`PCB_OFF_BRK_ADDR_B, 32'h0000_FFFF);
        // Channel A walks every mask and cycle code; channel B is random.
        for (int i = 0; i < 32; i++)
        begin
            m = 2'($urandom);
            for (int c = 0; c < 2; c++)
            begin
                brk[c] = 24'($urandom);
                cfg[c] = 8'($urandom) & 8'h7E;
            end
            cfg[0][5:1] = {3'(i), 2'(i >> 3)};
            a = brk[$urandom % 2] ^
                (($urandom % 3 == 0) ? 24'h0 : 24'h1 << ($urandom % 20));
            k = 2'($urandom % 3);
            x = 1'($urandom);
            for (int c = 0; c < 2; c++)
            begin
                wr(`PCB_OFF_BRK_ADDR_A + 8'(4 * c), {8'h0, brk[c]});
                wr(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c]});
                rd_chk(`PCB_OFF_BRK_ADDR_A + 8'(4 * c), {8'h0, brk[c]});
            end
            wr(`PCB_OFF_IRQ_MASK, {30'h0, m});
            bus_cycle(a, k, x);
            for (int c = 0; c < 2; c++)
                hv[c] = exp_hit(brk[c], cfg[c], a, k, x);
            repeat (2) @(posedge ref_clk);
            #1;
            check(brk_irq, |(hv & m));
            rd_chk(`PCB_OFF_IRQ_STAT, {30'h0, hv});
            wr(`PCB_OFF_IRQ_STAT, 32'h3);
            check(brk_irq, 1'h0);
            for (int c = 0; c < 2; c++)
            begin
                // Writing 0 before any read of the set flag must not clear.
                wr(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c]});
                rd_chk(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, hv[c], cfg[c][6:0]});
                if (hv[c])
                begin
                    wr(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c] | 8'h80});
                    rd_chk(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c] | 8'h80});
                    wr(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c]});
                    rd_chk(`PCB_OFF_CTL_A + 8'(4 * c), {24'h0, cfg[c]});
                end
            end
        end
        stop_test();
    end
endmodule : testbench
`default_nettype wire
